//--- common/dcf_pkg.sv
// Shared constants and carrier types for the dual-clock buffer block
package dcf_pkg;
  localparam int unsigned DATA_W = 9;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned PTR_W  = 17;
  localparam int unsigned OFS_W  = 16;
  // Depth option: 65,536 words (the 131,072 option needs ADDR_W = 17)
  localparam logic [PTR_W-1:0] CAP_STD   = 17'h10000;
  localparam logic [PTR_W-1:0] CAP_FALL_THROUGH_MODE  = 17'h10001;
  localparam logic [PTR_W-1:0] HALF_STD  = 17'h08000;
  localparam logic [PTR_W-1:0] HALF_FALL_THROUGH_MODE = 17'h08001;
  localparam logic [OFS_W-1:0] OFS_PAR   = 16'h007f;
  localparam logic [OFS_W-1:0] OFS_SER   = 16'h03ff;
  // Wishbone register byte addresses
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_EOFS   = 8'h04;
  localparam logic [7:0] ADR_FOFS   = 8'h08;
  localparam logic [7:0] ADR_FILL   = 8'h0c;
  // Status register bit positions
  localparam int unsigned ST_EMPTY = 0;
  localparam int unsigned ST_FULL  = 1;
  localparam int unsigned ST_AF    = 2;
  localparam int unsigned ST_AE    = 3;
  localparam int unsigned ST_HALF  = 4;
  localparam int unsigned ST_FALL_THROUGH_MODE  = 5;
  localparam int unsigned ST_SER   = 6;

  typedef struct packed {
    logic              wclk;
    logic              rclk;
    logic              wreq_n;
    logic              rreq_n;
    logic              drive_n;
    logic              sgate_n;
    logic              access_n;
    logic              sin;
    logic              finit_n;
    logic              pinit_n;
    logic [DATA_W-1:0] wdata;
  } dcf_pin_t;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [7:0]        adr;
    logic [3:0]        sel;
    logic [31:0]       dat;
  } dcf_wb_req_t;
endpackage : dcf_pkg

//--- design/dcf_top.sv
// Read port, flags and offset control of a 9-bit dual-clock buffer
// Summary of operation
// - Read request loads next word when nonempty
// - No request: output register holds its word unless fall-through and empty
// - Request mode reads every word; empty ignored
// - Empty flag clears two read edges after write
// - Fall-through shows first word third read edge
// - Output valid low with first shown word
// - Output valid rises only on true read
// - Serial bit shifts in per write edge
// - Serial gate high keeps offsets unchanged
// - Drive low enables data, high floats it
// - Full init strap picks offset preset, method
// - Writes by chosen method; reads always parallel
// - Access low enables offset load; bus reads ignore it
// - Full flag after depth writes, blocks writes
// - Input ready counts output register word too
// - Full side updates on write edges, two stages
// - Empty side two or three read stages
// - Almost full at depth minus full offset
// - Almost empty at n or n+1 words
// - Half flag: write sets, read clears
// - Half threshold differs between both modes
// - Read data is nine bits from register
// - Full init strap picks mode; then serial data
// - Write stores word unless full; else ignored
// - Full clears two write edges after read
// - Partial init keeps offsets, mode, method
`timescale 1ns/1ps
module dcf_top (
  input  wire logic                  SYS_CLK_I,  // 10 MHz system clock
  input  wire logic                  RESET_I,    // Async reset, high
  input  wire logic                  WCLK_I,     // Write side clock pin
  input  wire logic                  RCLK_I,     // Read side clock pin
  input  wire logic                  WREQ_N_I,   // Write request
  input  wire logic [dcf_pkg::DATA_W-1:0] WDATA_I, // Write data
  input  wire logic                  RREQ_N_I,   // Read request
  input  wire logic                  DRIVE_N_I,  // Output drive
  input  wire logic                  SGATE_N_I,  // Serial load gate
  input  wire logic                  ACCESS_N_I, // Offset access
  input  wire logic                  SIN_I,      // Serial in / mode
  input  wire logic                  FINIT_N_I,  // Full init
  input  wire logic                  PINIT_N_I,  // Partial init
  input  wire dcf_pkg::dcf_wb_req_t  WB_REQ_I,   // Wishbone request
  output logic [31:0]                WB_DAT_O,   // Wishbone read data
  output logic                       WB_ACK_O,   // Wishbone ack
  output logic [dcf_pkg::DATA_W-1:0] READ_DATA_O,  // Data out
  output logic                       READ_DATA_OE_O, // Data drive
  output logic                       EMPTY_N_O,  // Empty / out valid
  output logic                       FULL_N_O,   // Full / in ready
  output logic                       AF_N_O,     // Almost full
  output logic                       AE_N_O,     // Almost empty
  output logic                       HALF_N_O    // Half level
);
  import dcf_pkg::*;

  typedef struct packed {
    dcf_pin_t          s1;
    dcf_pin_t          s2;
    logic              wclk_d;
    logic              rclk_d;
    logic              fall_through_mode;
    logic              serial;
    logic [OFS_W-1:0]  e_ofs;
    logic [OFS_W-1:0]  f_ofs;
    logic [PTR_W-1:0]  wptr;
    logic [PTR_W-1:0]  tptr;
    logic [PTR_W-1:0]  rg1;
    logic [PTR_W-1:0]  rg2;
    logic [PTR_W-1:0]  wg1;
    logic [PTR_W-1:0]  wg2;
    logic [PTR_W-1:0]  wg3;
    logic [DATA_W-1:0] dout;
    logic              ovalid;
    logic              rd_ready;
    logic              full;
    logic              af_n;
    logic              ae_n;
    logic              half_n;
    logic              oe;
    logic              ack;
    logic [31:0]       rdat;
  } dcf_state_t;

  dcf_state_t        s_reg;
  dcf_state_t        s_next;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  dcf_pin_t          pins;
  logic              wev;
  logic              rev;
  logic              wr_fire;
  logic [PTR_W-1:0]  cap;
  logic [PTR_W-1:0]  half_t;
  logic [PTR_W-1:0]  fill_w;
  logic [PTR_W-1:0]  fill_r;
  logic [PTR_W-1:0]  wseen;
  logic [PTR_W-1:0]  cons;
  logic              wb_go;
  logic [31:0]       status;

  function automatic logic [PTR_W-1:0] to_gray(
      input logic [PTR_W-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction : to_gray

  function automatic logic [PTR_W-1:0] from_gray(
      input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    from_gray = b;
  endfunction : from_gray

  assign pins = '{wclk: WCLK_I, rclk: RCLK_I, wreq_n: WREQ_N_I,
                  rreq_n: RREQ_N_I, drive_n: DRIVE_N_I,
                  sgate_n: SGATE_N_I, access_n: ACCESS_N_I,
                  sin: SIN_I, finit_n: FINIT_N_I,
                  pinit_n: PINIT_N_I, wdata: WDATA_I};

  // Clock pins are sampled as levels; their rising edges become events
  assign wev = s_reg.s2.wclk & ~s_reg.wclk_d;
  assign rev = s_reg.s2.rclk & ~s_reg.rclk_d;
  assign cap = s_reg.fall_through_mode ? CAP_FALL_THROUGH_MODE : CAP_STD;
  assign half_t = s_reg.fall_through_mode ? HALF_FALL_THROUGH_MODE : HALF_STD;
  // Words the reader has taken; a word still in the output register is not counted
  assign cons = s_reg.tptr - {16'h0000, s_reg.ovalid};
  assign wb_go = WB_REQ_I.cyc & WB_REQ_I.stb;

  // Status mirrors the flag pins so software sees what the agents see
  always_comb begin
    status = '0;
    status[ST_EMPTY] = EMPTY_N_O;
    status[ST_FULL]  = FULL_N_O;
    status[ST_AF]    = s_reg.af_n;
    status[ST_AE]    = s_reg.ae_n;
    status[ST_HALF]  = s_reg.half_n;
    status[ST_FALL_THROUGH_MODE]  = s_reg.fall_through_mode;
    status[ST_SER]   = s_reg.serial;
  end

  always_comb begin
    s_next = s_reg;
    wr_fire = 1'b0;
    fill_w = '0;
    fill_r = '0;
    wseen = '0;
    s_next.s1 = pins;
    s_next.s2 = s_reg.s1;
    s_next.wclk_d = s_reg.s2.wclk;
    s_next.rclk_d = s_reg.s2.rclk;
    s_next.oe = ~s_reg.s2.drive_n;

    if (wev) begin
      // Read progress crosses on two write edges
      s_next.rg1 = to_gray(cons);
      s_next.rg2 = s_reg.rg1;
      fill_w = s_reg.wptr - from_gray(s_next.rg2);
      if (!s_reg.s2.wreq_n && fill_w < cap) begin
        wr_fire = 1'b1;
        s_next.wptr = s_reg.wptr + 17'h00001;
      end
      fill_w = s_next.wptr - from_gray(s_next.rg2);
      s_next.full = (fill_w >= cap);
      s_next.af_n = (fill_w < cap - {1'b0, s_reg.f_ofs});
      if (fill_w > half_t) begin
        s_next.half_n = 1'b0;
      end
      if (s_reg.serial && !s_reg.s2.sgate_n
          && !s_reg.s2.access_n) begin
        // First bit lands in the empty offset LSB after 32 shifts
        {s_next.f_ofs, s_next.e_ofs} =
          {s_reg.s2.sin, s_reg.f_ofs, s_reg.e_ofs[OFS_W-1:1]};
      end
    end

    if (rev) begin
      s_next.wg1 = to_gray(s_reg.wptr);
      s_next.wg2 = s_reg.wg1;
      s_next.wg3 = s_reg.wg2;
      // Fall-through adds a third stage before the word shows
      wseen = from_gray(s_reg.fall_through_mode ? s_next.wg3 : s_next.wg2);
      if (s_reg.fall_through_mode) begin
        if (wseen != s_reg.tptr
            && (!s_reg.ovalid || !s_reg.s2.rreq_n)) begin
          s_next.dout = mem[s_reg.tptr[ADDR_W-1:0]];
          s_next.tptr = s_reg.tptr + 17'h00001;
          s_next.ovalid = 1'b1;
        end else if (!s_reg.s2.rreq_n) begin
          s_next.ovalid = 1'b0;
        end
      end else if (!s_reg.s2.rreq_n
                   && wseen != s_reg.tptr) begin
        s_next.dout = mem[s_reg.tptr[ADDR_W-1:0]];
        s_next.tptr = s_reg.tptr + 17'h00001;
      end
      s_next.rd_ready = (wseen != s_next.tptr);
      fill_r = wseen - s_next.tptr + {16'h0000, s_next.ovalid};
      s_next.ae_n = s_reg.fall_through_mode
        ? (fill_r > {1'b0, s_reg.e_ofs} + 17'h00001)
        : (fill_r > {1'b0, s_reg.e_ofs});
      // A write edge that crosses half depth in this cycle wins
      if (fill_r <= half_t && !(wev && fill_w > half_t)) begin
        s_next.half_n = 1'b1;
      end
    end

    // Single-cycle classic slave; writes land on the acked edge
    s_next.ack = wb_go & ~s_reg.ack;
    if (wb_go && !s_reg.ack) begin
      case (WB_REQ_I.adr)
        ADR_STATUS: s_next.rdat = status;
        ADR_EOFS:   s_next.rdat = {16'h0000, s_reg.e_ofs};
        ADR_FOFS:   s_next.rdat = {16'h0000, s_reg.f_ofs};
        ADR_FILL:   s_next.rdat = {15'h0000, s_reg.wptr - cons};
        default:    s_next.rdat = 32'h0000_0000;
      endcase
    end
    // Parallel offset write only with access low and parallel method
    if (wb_go && s_reg.ack && WB_REQ_I.we && !s_reg.serial
        && !s_reg.s2.access_n) begin
      if (WB_REQ_I.adr == ADR_EOFS) begin
        if (WB_REQ_I.sel[0]) s_next.e_ofs[7:0] = WB_REQ_I.dat[7:0];
        if (WB_REQ_I.sel[1]) s_next.e_ofs[15:8] = WB_REQ_I.dat[15:8];
      end
      if (WB_REQ_I.adr == ADR_FOFS) begin
        if (WB_REQ_I.sel[0]) s_next.f_ofs[7:0] = WB_REQ_I.dat[7:0];
        if (WB_REQ_I.sel[1]) s_next.f_ofs[15:8] = WB_REQ_I.dat[15:8];
      end
    end

    if (!s_reg.s2.finit_n || !s_reg.s2.pinit_n) begin
      wr_fire = 1'b0;
      s_next.wptr = '0;
      s_next.tptr = '0;
      s_next.rg1 = '0;
      s_next.rg2 = '0;
      s_next.wg1 = '0;
      s_next.wg2 = '0;
      s_next.wg3 = '0;
      s_next.dout = '0;
      s_next.ovalid = 1'b0;
      s_next.rd_ready = 1'b0;
      s_next.full = 1'b0;
      s_next.af_n = 1'b1;
      s_next.ae_n = 1'b0;
      s_next.half_n = 1'b1;
    end
    if (!s_reg.s2.finit_n) begin
      s_next.fall_through_mode = s_reg.s2.sin;
      s_next.serial = s_reg.s2.access_n;
      s_next.e_ofs = s_reg.s2.access_n ? OFS_SER : OFS_PAR;
      s_next.f_ofs = s_reg.s2.access_n ? OFS_SER : OFS_PAR;
    end
  end

  // Reset leaves parallel presets; the synced init pin then runs a full init
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      s_reg <= '0;
      s_reg.e_ofs <= OFS_PAR;
      s_reg.f_ofs <= OFS_PAR;
      s_reg.af_n <= 1'b1;
      s_reg.half_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Storage has no reset; pointers alone define what is valid
  always_ff @(posedge SYS_CLK_I) begin
    if (wr_fire) begin
      mem[s_reg.wptr[ADDR_W-1:0]] <= s_reg.s2.wdata;
    end
  end

  assign READ_DATA_O = s_reg.dout;
  assign READ_DATA_OE_O = s_reg.oe;
  assign EMPTY_N_O = s_reg.fall_through_mode ? ~s_reg.ovalid : s_reg.rd_ready;
  assign FULL_N_O = s_reg.fall_through_mode ? s_reg.full : ~s_reg.full;
  assign AF_N_O = s_reg.af_n;
  assign AE_N_O = s_reg.ae_n;
  assign HALF_N_O = s_reg.half_n;
  assign WB_DAT_O = s_reg.rdat;
  assign WB_ACK_O = s_reg.ack;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);

  AST_NO_OVERFLOW: assert property (
    (s_reg.wptr - cons) <= cap)
    else $error("fill exceeds capacity");
  // A fall-through first word loads with no request, so it is left out
  AST_READ_HOLD: assert property (
    rev && s_reg.s2.rreq_n && s_reg.s2.finit_n && s_reg.s2.pinit_n
    && (!s_reg.fall_through_mode || s_reg.ovalid)
    |=> $stable(READ_DATA_O))
    else $error("output changed without request");
  AST_DRIVE: assert property (
    !$past(RESET_I) |-> READ_DATA_OE_O == !$past(s_reg.s2.drive_n))
    else $error("drive enable does not follow pin");
  AST_SERIAL_HOLD: assert property (
    s_reg.s2.sgate_n && s_reg.s2.finit_n && !(wb_go && s_reg.ack)
    |=> $stable(s_reg.e_ofs) && $stable(s_reg.f_ofs))
    else $error("offsets changed with gate high");
  AST_STD_READ_CAUSE: assert property (
    !s_reg.fall_through_mode && $changed(s_reg.tptr) && $past(s_reg.s2.pinit_n)
    && $past(s_reg.s2.finit_n) |-> $past(rev && !s_reg.s2.rreq_n))
    else $error("request mode read without request");
  AST_VALID_DROP: assert property (
    s_reg.fall_through_mode && $rose(EMPTY_N_O) && $past(s_reg.s2.pinit_n)
    && $past(s_reg.s2.finit_n) |-> $past(rev && !s_reg.s2.rreq_n))
    else $error("output valid rose without true read");
  AST_HALF_SET: assert property (
    $fell(HALF_N_O) |-> $past(wev))
    else $error("half flag set off a write edge");
  AST_PART_KEEP: assert property (
    !s_reg.s2.pinit_n && s_reg.s2.finit_n && !wev && !(wb_go && s_reg.ack)
    |=> $stable(s_reg.fall_through_mode) && $stable(s_reg.e_ofs))
    else $error("partial init lost settings");
  AST_FULL_EDGE: assert property (
    $changed(s_reg.full) && $past(s_reg.s2.pinit_n)
    && $past(s_reg.s2.finit_n) |-> $past(wev))
    else $error("full flag moved off a write edge");

  // Init cycles are left out below: either init moves every flag at once
  AST_AF_EDGE: assert property (
    $changed(s_reg.af_n) && $past(s_reg.s2.pinit_n)
    && $past(s_reg.s2.finit_n) |-> $past(wev))
    else $error("almost full moved off a write edge");
  AST_AE_EDGE: assert property (
    $changed(s_reg.ae_n) && $past(s_reg.s2.pinit_n)
    && $past(s_reg.s2.finit_n) |-> $past(rev))
    else $error("almost empty moved off a read edge");
  AST_EMPTY_EDGE: assert property (
    $changed(s_reg.rd_ready) && $past(s_reg.s2.pinit_n)
    && $past(s_reg.s2.finit_n) |-> $past(rev))
    else $error("empty flag moved off a read edge");
  AST_HALF_CLEAR: assert property (
    $rose(HALF_N_O) && $past(s_reg.s2.pinit_n)
    && $past(s_reg.s2.finit_n) |-> $past(rev))
    else $error("half flag cleared off a read edge");
  AST_WRITE_ROOM: assert property (
    wr_fire |-> (s_reg.wptr - cons) < cap)
    else $error("write taken with no room");
  AST_NO_UNDERRUN: assert property (
    $changed(s_reg.tptr) && $past(s_reg.s2.pinit_n)
    && $past(s_reg.s2.finit_n) |-> $past(s_reg.wptr != s_reg.tptr))
    else $error("read taken from an empty buffer");
  AST_VALID_EDGE: assert property (
    $rose(s_reg.ovalid) |-> $past(rev))
    else $error("output valid set off a read edge");
  AST_LAST_STAYS: assert property (
    s_reg.fall_through_mode && $rose(EMPTY_N_O) && $past(s_reg.s2.pinit_n)
    && $past(s_reg.s2.finit_n) |-> $stable(READ_DATA_O))
    else $error("last word lost when output valid dropped");
  AST_PAR_ONLY: assert property (
    !s_reg.serial && s_reg.s2.finit_n && !(wb_go && s_reg.ack)
    |=> $stable(s_reg.e_ofs) && $stable(s_reg.f_ofs))
    else $error("parallel offsets changed off the bus");
  AST_ACCESS_LOCK: assert property (
    s_reg.s2.access_n && s_reg.s2.finit_n
    |=> $stable(s_reg.e_ofs) && $stable(s_reg.f_ofs))
    else $error("offsets changed with access high");
  AST_ACK_PULSE: assert property (
    WB_ACK_O |=> !WB_ACK_O)
    else $error("bus ack held for two cycles");

  COV_FULL: cover property (s_reg.full && !s_reg.fall_through_mode);
  COV_FT_FIRST: cover property (s_reg.fall_through_mode && $rose(s_reg.ovalid));
  COV_SERIAL: cover property (wev && s_reg.serial && !s_reg.s2.sgate_n
                              && !s_reg.s2.access_n);
  COV_HALF: cover property ($rose(HALF_N_O));
  COV_VALID_DROP: cover property (s_reg.fall_through_mode && $rose(EMPTY_N_O));
endmodule : dcf_top

//--- bench/dcf_peer.sv
// Writer and reader agent model driving the buffer's data-side pins
`timescale 1ns/1ps
module dcf_peer (
  input  wire logic                   clk_i,    // System clock
  output logic                        wclk_o,   // Write side clock
  output logic                        rclk_o,   // Read side clock
  output logic                        wreq_n_o, // Write request
  output logic [dcf_pkg::DATA_W-1:0]  wdata_o,  // Write data
  output logic                        rreq_n_o  // Read request
);
  import dcf_pkg::*;
  // Phases span three system cycles so the pin sampler sees every edge
  localparam int PH = 3;
  initial begin
    wclk_o = 1'b0;
    rclk_o = 1'b0;
    wreq_n_o = 1'b1;
    wdata_o = '0;
    rreq_n_o = 1'b1;
  end
  task automatic wait_ph;
    repeat (PH) @(posedge clk_i);
  endtask : wait_ph
  // Clocks stand still between pulses; request held across the edge
  task automatic wpulse(input logic req_n, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    wreq_n_o <= req_n;
    wdata_o <= d;
    wait_ph();
    wclk_o <= 1'b1;
    wait_ph();
    wclk_o <= 1'b0;
    wait_ph();
    wreq_n_o <= 1'b1;
    wdata_o <= ~d;  // Released data must not look still valid
  endtask : wpulse
  task automatic rpulse(input logic req_n);
    @(posedge clk_i);
    rreq_n_o <= req_n;
    wait_ph();
    rclk_o <= 1'b1;
    wait_ph();
    rclk_o <= 1'b0;
    wait_ph();
    rreq_n_o <= 1'b1;
  endtask : rpulse
endmodule : dcf_peer

//--- bench/tb.sv
// Self-checking bench for the buffer read port, flags and offsets
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb;
  import dcf_pkg::*;
  localparam int LIMIT = 20000;  // Sequence needs about 700 cycles
  localparam logic [31:0] SER_VAL = 32'h00050001;
  logic              sys_clk = 1'b0;
  logic              reset, drive_n, sgate_n, access_n, sin;
  logic              finit_n, pinit_n, wclk, rclk, wreq_n, rreq_n;
  logic [DATA_W-1:0] wdata, rdata;
  logic              oe, empty_n, full_n, af_n, ae_n, half_n, wb_ack;
  logic [31:0]       wb_dat, v;
  dcf_wb_req_t       wb_req;
  int                err_total = 0, n_checks = 0, cycles = 0;
  logic [DATA_W-1:0] w [3] = '{9'h1a5, 9'h05a, 9'h1ff};

  always #50 sys_clk = ~sys_clk;

  dcf_top i_dut (
    .SYS_CLK_I      (sys_clk),
    .RESET_I        (reset),
    .WCLK_I         (wclk),
    .RCLK_I         (rclk),
    .WREQ_N_I       (wreq_n),
    .WDATA_I        (wdata),
    .RREQ_N_I       (rreq_n),
    .DRIVE_N_I      (drive_n),
    .SGATE_N_I      (sgate_n),
    .ACCESS_N_I     (access_n),
    .SIN_I          (sin),
    .FINIT_N_I      (finit_n),
    .PINIT_N_I      (pinit_n),
    .WB_REQ_I       (wb_req),
    .WB_DAT_O       (wb_dat),
    .WB_ACK_O       (wb_ack),
    .READ_DATA_O    (rdata),
    .READ_DATA_OE_O (oe),
    .EMPTY_N_O      (empty_n),
    .FULL_N_O       (full_n),
    .AF_N_O         (af_n),
    .AE_N_O         (ae_n),
    .HALF_N_O       (half_n)
  );

  dcf_peer u_peer (.clk_i(sys_clk), .wclk_o(wclk), .rclk_o(rclk),
    .wreq_n_o(wreq_n), .wdata_o(wdata), .rreq_n_o(rreq_n));

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      summarize();
    end
  end

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle

  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    wb_req <= '{1'b1, 1'b1, we, adr, 4'h3, d};
    // Only the bench timeout ends a wait for the acknowledge
    do begin
      @(posedge sys_clk);
    end while (wb_ack !== 1'b1);
    q = wb_dat;
    wb_req <= '0;
  endtask : wb

  task automatic chk_reg(input logic [7:0] adr, input logic [31:0] m,
                         input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, adr, 32'h0, q);
    `CHK(q & m, e)
  endtask : chk_reg

  // Flags ordered half, almost-empty, almost-full, full, empty
  task automatic chk_flags(input logic [4:0] e);
    `CHK({half_n, ae_n, af_n, full_n, empty_n}, e)
  endtask : chk_flags

  // Straps are held past the synced release so the init sees them
  task automatic finit(input logic acc_n, input logic s);
    access_n <= acc_n;
    sin <= s;
    finit_n <= 1'b0;
    idle(6);
    finit_n <= 1'b1;
    idle(4);
    access_n <= 1'b1;
    sin <= 1'b0;
    idle(8);
  endtask : finit

  task automatic pulse_pinit;
    pinit_n <= 1'b0;
    idle(6);
    pinit_n <= 1'b1;
    idle(8);
  endtask : pulse_pinit

  initial begin
    reset = 1'b1;
    drive_n = 1'b0;
    sgate_n = 1'b1;
    access_n = 1'b0;
    sin = 1'b0;
    finit_n = 1'b0;
    pinit_n = 1'b1;
    wb_req = '0;
    idle(12);
    reset <= 1'b0;
    finit(1'b0, 1'b0);
    chk_flags(5'b10110);
    `CHK(rdata, 9'h000)
    `CHK(oe, 1'b1)
    chk_reg(ADR_STATUS, 32'h7f, 32'h16);
    chk_reg(ADR_EOFS, 32'hffff, 32'h7f);
    chk_reg(8'h10, 32'hffffffff, 32'h0);
    wb(1'b1, ADR_EOFS, 32'h2, v);
    chk_reg(ADR_EOFS, 32'hffff, 32'h7f);
    access_n <= 1'b0;
    idle(4);
    wb(1'b1, ADR_EOFS, 32'h2, v);
    wb(1'b1, ADR_FOFS, 32'hffff, v);
    access_n <= 1'b1;
    chk_reg(ADR_EOFS, 32'hffff, 32'h2);
    chk_reg(ADR_FOFS, 32'hffff, 32'hffff);
    u_peer.wpulse(1'b0, w[0]);
    chk_flags(5'b10010);
    u_peer.rpulse(1'b1);
    `CHK(empty_n, 1'b0)
    u_peer.rpulse(1'b1);
    `CHK(empty_n, 1'b1)
    u_peer.wpulse(1'b0, w[1]);
    u_peer.wpulse(1'b0, w[2]);
    u_peer.rpulse(1'b1);
    u_peer.rpulse(1'b1);
    chk_flags(5'b11011);
    chk_reg(ADR_FILL, 32'h1ffff, 32'h3);
    `CHK(rdata, 9'h000)
    for (int i = 0; i < 3; i++) begin
      u_peer.rpulse(1'b0);
      `CHK(rdata, w[i])
    end
    `CHK({ae_n, empty_n}, 2'b00)
    u_peer.rpulse(1'b0);
    `CHK(rdata, w[2])
    drive_n <= 1'b1;
    idle(5);
    `CHK(oe, 1'b0)
    drive_n <= 1'b0;
    u_peer.wpulse(1'b0, w[0]);
    pulse_pinit();
    chk_flags(5'b10110);
    chk_reg(ADR_EOFS, 32'hffff, 32'h2);
    chk_reg(ADR_FILL, 32'h1ffff, 32'h0);
    chk_reg(ADR_STATUS, 32'h60, 32'h0);
    finit(1'b1, 1'b1);
    chk_reg(ADR_STATUS, 32'h7f, 32'h75);
    chk_reg(ADR_FOFS, 32'hffff, 32'h3ff);
    access_n <= 1'b0;
    for (int i = 0; i < 34; i++) begin
      sin <= (i < 32) ? SER_VAL[i] : 1'b1;
      sgate_n <= (i < 32) ? 1'b0 : 1'b1;
      u_peer.wpulse(1'b1, 9'h000);
    end
    wb(1'b1, ADR_EOFS, 32'h33, v);
    access_n <= 1'b1;
    chk_reg(ADR_EOFS, 32'hffff, 32'h1);
    chk_reg(ADR_FOFS, 32'hffff, 32'h5);
    u_peer.wpulse(1'b0, w[0]);
    u_peer.rpulse(1'b1);
    u_peer.rpulse(1'b1);
    `CHK(empty_n, 1'b1)
    u_peer.rpulse(1'b1);
    `CHK({empty_n, rdata}, {1'b0, w[0]})
    `CHK(full_n, 1'b0)
    u_peer.wpulse(1'b0, w[1]);
    u_peer.rpulse(1'b1);
    u_peer.rpulse(1'b1);
    `CHK(rdata, w[0])
    u_peer.rpulse(1'b0);
    `CHK({empty_n, rdata}, {1'b0, w[1]})
    u_peer.rpulse(1'b0);
    `CHK({empty_n, rdata}, {1'b1, w[1]})
    u_peer.rpulse(1'b0);
    `CHK({empty_n, rdata}, {1'b1, w[1]})
    summarize();
  end
endmodule : tb
